// file: cspm_defs.vh
`ifndef CSPM_DEFS_VH
`define CSPM_DEFS_VH

// Register indices on the plain register port
`define CSPM_ADDR_W          4
`define CSPM_REG_CTRL        4'h0
`define CSPM_REG_TRIM        4'h1
`define CSPM_REG_STATUS      4'h2
`define CSPM_REG_CONFIG      4'h3

// Control register fields
`define CSPM_CTRL_IDLE_BIT   7
`define CSPM_CTRL_PRI_FLAG   3
`define CSPM_CTRL_SCS_HI     1
`define CSPM_CTRL_SCS_LO     0
`define CSPM_CTRL_RESET      8'h00

// Trim register
`define CSPM_TRIM_W          6
`define CSPM_TRIM_RESET      6'h00

// Clock source select codes
`define CSPM_SRC_PRIMARY     2'h2
`define CSPM_SRC_SECONDARY   2'h1
`define CSPM_SRC_INTERNAL    2'h3

// Primary oscillator configuration codes
`define CSPM_CFG_INTERNAL    3'h0
`define CSPM_CFG_CRYSTAL     3'h4
`define CSPM_CFG_EXTCLK      3'h5
`define CSPM_CFG_EXTCLK_PLL  3'h6
`define CSPM_CFG_CRYSTAL_PLL 3'h7

// Timing
`define CSPM_CLK_MHZ         100
`define CSPM_TRIM_SETTLE_US  1000
`define CSPM_TRIM_SETTLE_CYC (`CSPM_TRIM_SETTLE_US * `CSPM_CLK_MHZ)
`define CSPM_PWRUP_CYC       65536
`define CSPM_OSC_START_CYC   1024
`define CSPM_READY_CYC       16
`define CSPM_SW_OLD_CYC      2
`define CSPM_SW_NEW_CYC      4

`endif

// file: cspm_clock_power_ctrl.v
`timescale 1ns/100ps
`include "cspm_defs.vh"

module cspm_clock_power_ctrl #(
	parameter PWRUP_CYC    = `CSPM_PWRUP_CYC,
	parameter SETTLE_CYC   = `CSPM_TRIM_SETTLE_CYC
) (
	input  wire                      sys_clk,
	input  wire                      sys_rst,
	input  wire [`CSPM_ADDR_W-1:0]   reg_addr,
	input  wire [7:0]                reg_wdata,
	input  wire                      reg_wr,
	input  wire                      reg_rd,
	output reg  [7:0]                reg_rdata,
	input  wire                      sleep_cmd,
	input  wire                      wake_event,
	input  wire [2:0]                primary_osc_config,
	input  wire                      timer1_osc_enable,
	input  wire                      watchdog_enable,
	input  wire                      osc_in_tick,
	output reg                       device_reset,
	output reg                       cpu_clk_en,
	output reg                       periph_clk_en,
	output reg  [1:0]                active_source,
	output reg                       primary_osc_en,
	output reg                       secondary_osc_en,
	output reg                       fast_internal_osc_en,
	output reg                       slow_internal_osc_en,
	output reg  [`CSPM_TRIM_W-1:0]   fast_osc_trim,
	output reg                       trim_settling,
	output reg                       feedback_inv_en,
	output reg                       osc_pins_as_port,
	output reg                       osc_out_pin,
	output reg                       osc_out_pin_oe,
	output reg                       primary_clock_active_flag,
	output reg                       secondary_clock_active_flag
);

	localparam ST_PWRUP  = 3'h0;
	localparam ST_OSTART = 3'h1;
	localparam ST_READY  = 3'h2;
	localparam ST_RUN    = 3'h3;
	localparam ST_SWITCH = 3'h4;
	localparam ST_IDLE   = 3'h5;
	localparam ST_SLEEP  = 3'h6;

	// Input synchronisers
	reg  [2:0]  cfg_s1, cfg_s2;
	reg  [4:0]  in_s1, in_s2;
	reg         tick_d;
	wire        sleep_s   = in_s2[0];
	wire        wake_s    = in_s2[1];
	wire        t1_en_s   = in_s2[2];
	wire        wdt_en_s  = in_s2[3];
	wire        tick_s    = in_s2[4];
	wire        tick_rise = tick_s & ~tick_d;

	reg  [2:0]                state;
	reg                       idle_enable_bit;
	reg  [1:0]                clock_source_select;
	reg  [`CSPM_TRIM_W-1:0]   freq_trim_field;
	reg  [16:0]               cnt;
	reg  [16:0]               settle_cnt;
	reg  [2:0]                sw_cnt;
	reg  [1:0]                sw_target;
	reg                       sleep_d;
	reg  [1:0]                div_cnt;

	wire is_crystal  = (cfg_s2 == `CSPM_CFG_CRYSTAL) || (cfg_s2 == `CSPM_CFG_CRYSTAL_PLL);
	wire is_extclk   = (cfg_s2 == `CSPM_CFG_EXTCLK) || (cfg_s2 == `CSPM_CFG_EXTCLK_PLL);
	wire is_internal = (cfg_s2 == `CSPM_CFG_INTERNAL);
	wire sleep_rise  = sleep_s & ~sleep_d;

	// Primary code means the internal block when no external oscillator is fitted
	wire [1:0] sel_src  = (clock_source_select == `CSPM_SRC_PRIMARY && is_internal) ?
	                      `CSPM_SRC_INTERNAL : clock_source_select;

	// Effective source: secondary only when timer oscillator enabled
	wire [1:0] want_src = (sel_src == `CSPM_SRC_SECONDARY && !t1_en_s) ?
	                      active_source :
	                      (sel_src == 2'h0 ? active_source : sel_src);

	// Divide-by-four output clock for external clock modes
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_cnt <= 2'h0;
		end else begin
			div_cnt <= div_cnt + 2'h1;
		end
	end

	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_s1 <= 3'h0;
			cfg_s2 <= 3'h0;
			in_s1  <= 5'h00;
			in_s2  <= 5'h00;
			tick_d <= 1'b0;
			sleep_d <= 1'b0;
		end else begin
			cfg_s1 <= primary_osc_config;
			cfg_s2 <= cfg_s1;
			in_s1  <= {osc_in_tick, watchdog_enable, timer1_osc_enable, wake_event, sleep_cmd};
			in_s2  <= in_s1;
			tick_d <= tick_s;
			sleep_d <= sleep_s;
		end
	end

	// Register writes and trim settling
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			idle_enable_bit     <= 1'b0;
			clock_source_select <= `CSPM_SRC_PRIMARY;
			freq_trim_field     <= `CSPM_TRIM_RESET;
			fast_osc_trim       <= `CSPM_TRIM_RESET;
			settle_cnt          <= 17'h00000;
			trim_settling       <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == `CSPM_REG_CTRL) begin
				idle_enable_bit     <= reg_wdata[`CSPM_CTRL_IDLE_BIT];
				clock_source_select <= reg_wdata[`CSPM_CTRL_SCS_HI:`CSPM_CTRL_SCS_LO];
			end
			if (reg_wr && reg_addr == `CSPM_REG_TRIM) begin
				freq_trim_field <= reg_wdata[`CSPM_TRIM_W-1:0];
				settle_cnt      <= 17'h00000;
				trim_settling   <= 1'b1;
			end else if (fast_osc_trim != freq_trim_field) begin
				// One step toward the target per settle slice; step direction from an unsigned compare
				if (settle_cnt >= SETTLE_CYC / 64 - 1) begin
					settle_cnt <= 17'h00000;
					if (freq_trim_field > fast_osc_trim)
						fast_osc_trim <= fast_osc_trim + 6'h01;
					else
						fast_osc_trim <= fast_osc_trim - 6'h01;
				end else begin
					settle_cnt <= settle_cnt + 17'h00001;
				end
			end else begin
				trim_settling <= 1'b0;
				settle_cnt    <= 17'h00000;
			end
		end
	end

	// Power-up sequence, mode control, clock switching
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state         <= ST_PWRUP;
			cnt           <= 17'h00000;
			sw_cnt        <= 3'h0;
			sw_target     <= `CSPM_SRC_INTERNAL;
			active_source <= `CSPM_SRC_INTERNAL;
			device_reset  <= 1'b1;
			cpu_clk_en    <= 1'b0;
			periph_clk_en <= 1'b0;
		end else begin
			case (state)
			ST_PWRUP: begin
				if (cnt >= PWRUP_CYC - 1) begin
					cnt   <= 17'h00000;
					state <= is_crystal ? ST_OSTART : ST_READY;
				end else begin
					cnt <= cnt + 17'h00001;
				end
			end
			ST_OSTART: begin
				if (tick_rise) begin
					if (cnt >= `CSPM_OSC_START_CYC - 1) begin
						cnt   <= 17'h00000;
						state <= ST_READY;
					end else begin
						cnt <= cnt + 17'h00001;
					end
				end
			end
			ST_READY: begin
				if (cnt >= `CSPM_READY_CYC - 1) begin
					cnt           <= 17'h00000;
					state         <= ST_RUN;
					device_reset  <= 1'b0;
					cpu_clk_en    <= 1'b1;
					periph_clk_en <= 1'b1;
					active_source <= is_internal ? `CSPM_SRC_INTERNAL : `CSPM_SRC_PRIMARY;
				end else begin
					cnt <= cnt + 17'h00001;
				end
			end
			ST_RUN, ST_IDLE: begin
				if (want_src != active_source) begin
					sw_target     <= want_src;
					sw_cnt        <= 3'h0;
					cpu_clk_en    <= 1'b0;
					periph_clk_en <= 1'b0;
					state         <= ST_SWITCH;
				end else if (sleep_rise && idle_enable_bit) begin
					cpu_clk_en <= 1'b0;
					state      <= ST_IDLE;
				end else if (sleep_rise) begin
					cpu_clk_en    <= 1'b0;
					periph_clk_en <= 1'b0;
					state         <= ST_SLEEP;
				end else if (state == ST_IDLE && wake_s) begin
					cpu_clk_en <= 1'b1;
					state      <= ST_RUN;
				end
			end
			ST_SWITCH: begin
				// Clock held off for old plus new source cycles
				if (sw_cnt >= `CSPM_SW_OLD_CYC + `CSPM_SW_NEW_CYC - 1) begin
					active_source <= sw_target;
					periph_clk_en <= 1'b1;
					cpu_clk_en    <= 1'b1;
					state         <= ST_RUN;
				end else begin
					sw_cnt <= sw_cnt + 3'h1;
				end
			end
			ST_SLEEP: begin
				if (wake_s) begin
					cpu_clk_en    <= 1'b1;
					periph_clk_en <= 1'b1;
					state         <= ST_RUN;
				end
			end
			default: state <= ST_PWRUP;
			endcase
		end
	end

	// Oscillator enables, pin states and status flags
	reg next_primary_osc_en;
	reg next_fast_int_osc_en;
	reg next_slow_int_osc_en;
	reg next_feedback_inv_en;
	reg next_osc_out_pin;
	reg next_pri_flag;
	reg next_sec_flag;

	always @* begin
		next_primary_osc_en  = 1'b0;
		next_fast_int_osc_en = 1'b0;
		next_slow_int_osc_en = wdt_en_s;
		next_feedback_inv_en = 1'b0;
		next_osc_out_pin     = 1'b0;
		next_pri_flag        = 1'b0;
		next_sec_flag        = 1'b0;
		case (state)
		ST_SLEEP: begin
			// Only the watchdog's slow oscillator and the timer1 secondary oscillator may stay on
			next_slow_int_osc_en = wdt_en_s;
		end
		ST_PWRUP, ST_OSTART, ST_READY: begin
			// Primary must run while the start-up counter watches it
			next_primary_osc_en  = !is_internal;
			next_fast_int_osc_en = (active_source == `CSPM_SRC_INTERNAL);
			next_slow_int_osc_en = wdt_en_s || (state == ST_PWRUP) ||
			                       (active_source == `CSPM_SRC_INTERNAL);
			next_feedback_inv_en = is_crystal;
			next_osc_out_pin     = is_extclk && div_cnt[1];
		end
		default: begin
			// Primary kept alive while it is the source or the switch target
			next_primary_osc_en  = !is_internal &&
			                       (active_source == `CSPM_SRC_PRIMARY ||
			                        sw_target == `CSPM_SRC_PRIMARY);
			next_fast_int_osc_en = (active_source == `CSPM_SRC_INTERNAL);
			next_slow_int_osc_en = wdt_en_s ||
			                       (active_source == `CSPM_SRC_INTERNAL);
			next_feedback_inv_en = is_crystal;
			next_osc_out_pin     = is_extclk && div_cnt[1];
			next_pri_flag        = (state == ST_RUN || state == ST_IDLE) &&
			                       (active_source == `CSPM_SRC_PRIMARY);
			next_sec_flag        = (state == ST_RUN || state == ST_IDLE) &&
			                       (active_source == `CSPM_SRC_SECONDARY);
		end
		endcase
	end

	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			primary_osc_en              <= 1'b0;
			secondary_osc_en            <= 1'b0;
			fast_internal_osc_en        <= 1'b0;
			slow_internal_osc_en        <= 1'b1;
			feedback_inv_en             <= 1'b0;
			osc_pins_as_port            <= 1'b0;
			osc_out_pin                 <= 1'b0;
			osc_out_pin_oe              <= 1'b0;
			primary_clock_active_flag   <= 1'b0;
			secondary_clock_active_flag <= 1'b0;
		end else begin
			primary_osc_en              <= next_primary_osc_en;
			secondary_osc_en            <= t1_en_s;
			fast_internal_osc_en        <= next_fast_int_osc_en;
			slow_internal_osc_en        <= next_slow_int_osc_en;
			feedback_inv_en             <= next_feedback_inv_en;
			osc_pins_as_port            <= is_internal;
			osc_out_pin_oe              <= is_extclk;
			osc_out_pin                 <= next_osc_out_pin;
			primary_clock_active_flag   <= next_pri_flag;
			secondary_clock_active_flag <= next_sec_flag;
		end
	end

	// Register read, data one cycle after strobe
	reg  [7:0] next_rdata;

	always @* begin
		next_rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
			`CSPM_REG_CTRL:   next_rdata = {idle_enable_bit, 3'h0, primary_clock_active_flag,
			                                1'b0, clock_source_select};
			`CSPM_REG_TRIM:   next_rdata = {2'h0, freq_trim_field};
			`CSPM_REG_STATUS: next_rdata = {trim_settling, secondary_clock_active_flag,
			                                primary_clock_active_flag, state, active_source};
			`CSPM_REG_CONFIG: next_rdata = {5'h00, cfg_s2};
			default:          next_rdata = 8'h00;
			endcase
		end
	end

	// Idle data is zero so a stale read never lingers on the bus
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

endmodule // cspm_clock_power_ctrl

// file: cspm_osc_model.sv
`timescale 1ns/100ps
module cspm_osc_model #(
	parameter HALF_NS = 13
) (
	input  wire run,
	output reg  tick
);
	// A crystal that is switched off stands still at low level
	initial begin
		tick = 1'b0;
		forever begin
			#(HALF_NS);
			tick <= run ? ~tick : 1'b0;
		end
	end
endmodule // cspm_osc_model

// file: cspm_props.sv
`timescale 1ns/100ps
module cspm_props #(
	parameter PWRUP_CYC  = 64,
	parameter SETTLE_CYC = 640
) (
	input wire       sys_clk,
	input wire       sys_rst,
	input wire       reg_rd,
	input wire [7:0] reg_rdata,
	input wire [2:0] primary_osc_config,
	input wire       watchdog_enable,
	input wire       device_reset,
	input wire       cpu_clk_en,
	input wire       periph_clk_en,
	input wire [1:0] active_source,
	input wire       primary_osc_en,
	input wire       slow_internal_osc_en,
	input wire [5:0] fast_osc_trim,
	input wire       trim_settling,
	input wire       feedback_inv_en,
	input wire       osc_out_pin,
	input wire       primary_clock_active_flag,
	input wire       secondary_clock_active_flag
);
	int rel_cnt;
	int set_cnt;
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rel_cnt <= 0;
			set_cnt <= 0;
		end else begin
			rel_cnt <= device_reset ? rel_cnt + 1 : 0;
			set_cnt <= trim_settling ? set_cnt + 1 : 0;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// Longer than any switch pause, so only sleep matches
	sequence s_off;
		!cpu_clk_en && !periph_clk_en && !device_reset;
	endsequence
	sequence s_asleep;
		s_off [*8];
	endsequence
	AST_RDATA_ONLY_AFTER_READ: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	AST_WDT_KEEPS_SLOW: assert property (watchdog_enable [*5] |-> slow_internal_osc_en)
		else $error("slow oscillator off with watchdog on");
	AST_IDLE_GATES_CPU: assert property (cpu_clk_en |-> periph_clk_en)
		else $error("cpu clocked without peripherals");
	AST_FLAGS_EXCLUSIVE: assert property (!(primary_clock_active_flag && secondary_clock_active_flag))
		else $error("both source flags set");
	AST_PRI_FLAG_SRC: assert property (primary_clock_active_flag |-> active_source == 2'h2)
		else $error("primary flag without primary source");
	AST_SEC_FLAG_SRC: assert property (secondary_clock_active_flag |-> active_source == 2'h1)
		else $error("secondary flag without secondary source");
	AST_SLEEP_STOPS_PRIMARY: assert property (s_asleep |-> !primary_osc_en && !feedback_inv_en)
		else $error("primary running in sleep");
	AST_EXTCLK_SLEEP_LOW: assert property ((primary_osc_config == 3'h5) throughout s_asleep |-> !osc_out_pin)
		else $error("clock output not low in sleep");
	AST_POWERUP_HOLD: assert property ($fell(device_reset) |-> rel_cnt >= PWRUP_CYC + 14)
		else $error("device reset released too early");
	AST_TRIM_STEP: assert property ($changed(fast_osc_trim) |-> (fast_osc_trim - $past(fast_osc_trim)) inside {6'h01, 6'h3f})
		else $error("trim jumped more than one step");
	AST_TRIM_SETTLE_BOUND: assert property (set_cnt <= SETTLE_CYC)
		else $error("trim settling too long");
endmodule // cspm_props
bind cspm_clock_power_ctrl cspm_props #(.PWRUP_CYC(PWRUP_CYC), .SETTLE_CYC(SETTLE_CYC))
	u_props (.*);

// file: tb.sv
`timescale 1ns/100ps
module tb;
	localparam PW = 64;
	localparam ST = 640;
	logic       sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic       sleep_cmd = 1'b0, wake_event = 1'b0, timer1_osc_enable = 1'b0;
	logic       watchdog_enable = 1'b0, osc_in_tick;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, rd_val;
	logic [2:0] primary_osc_config = 3'h4;
	logic       device_reset, cpu_clk_en, periph_clk_en, primary_osc_en, secondary_osc_en;
	logic       fast_internal_osc_en, slow_internal_osc_en, trim_settling, feedback_inv_en;
	logic       osc_pins_as_port, osc_out_pin, osc_out_pin_oe;
	logic       primary_clock_active_flag, secondary_clock_active_flag;
	logic [1:0] active_source;
	logic [5:0] fast_osc_trim;
	logic [1:0] scs_t [4] = '{2'h3, 2'h1, 2'h1, 2'h2};
	logic [1:0] src_t [4] = '{2'h3, 2'h3, 2'h1, 2'h2};
	int         err_count = 0, total_checks = 0, i, n, m_trim, m_old, m_off;
	cspm_clock_power_ctrl #(.PWRUP_CYC(PW), .SETTLE_CYC(ST)) uut (.*);
	cspm_osc_model u_osc (.run(primary_osc_en | device_reset), .tick(osc_in_tick));
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
		@(posedge sys_clk);
	endtask
	task give_verdict;
		if (err_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		n = $urandom(32'haa39);
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		for (n = 0; n < 4000 && device_reset !== 1'b0; n++) @(posedge sys_clk);
		chk(n >= PW + 2600, 1'b1);
		chk(device_reset, 1'b0);
		rd(4'h0);
		chk(rd_val & 8'h83, 8'h02);
		chk(primary_clock_active_flag, 1'b1);
		rd(4'h9);
		chk(rd_val, 8'h00);
		for (i = 0; i < 3; i++) begin
			m_trim = (i == 0) ? $urandom % 64 : (i == 1 ? 63 : 0);
			m_old = fast_osc_trim;
			wr(4'h1, m_trim[7:0]);
			repeat (ST / 64 + 3) @(posedge sys_clk);
			chk((fast_osc_trim > m_old) == (m_trim > m_old), 1'b1);
			repeat (ST + 8) @(posedge sys_clk);
			chk(fast_osc_trim, m_trim[7:0]);
			chk(trim_settling, 1'b0);
			rd(4'h1);
			chk(rd_val[5:0], m_trim[7:0]);
		end
		for (i = 0; i < 4; i++) begin
			timer1_osc_enable <= (i >= 2);
			repeat (3) @(posedge sys_clk);
			wr(4'h0, {6'h00, scs_t[i]});
			m_off = 0;
			for (n = 0; n < 14; n++) begin
				@(posedge sys_clk);
				m_off += !cpu_clk_en;
			end
			chk(i == 1 ? m_off == 0 : m_off >= 5 && m_off <= 7, 1'b1);
			chk(active_source, src_t[i]);
			chk(primary_clock_active_flag, src_t[i] == 2'h2);
			chk(secondary_clock_active_flag, src_t[i] == 2'h1);
			chk(primary_osc_en, src_t[i] == 2'h2);
			chk(secondary_osc_en, i >= 2);
			chk(fast_internal_osc_en, src_t[i] == 2'h3);
		end
		for (i = 0; i < 2; i++) begin
			wr(4'h0, {i[0], 7'h02});
			watchdog_enable <= 1'b1;
			sleep_cmd <= 1'b1;
			repeat (14) @(posedge sys_clk);
			chk(cpu_clk_en, 1'b0);
			chk(periph_clk_en, i[0]);
			chk(primary_osc_en, i[0]);
			chk(feedback_inv_en, i[0]);
			chk(slow_internal_osc_en, 1'b1);
			sleep_cmd <= 1'b0;
			wake_event <= 1'b1;
			for (n = 0; n < 4000 && cpu_clk_en !== 1'b1; n++) @(posedge sys_clk);
			wake_event <= 1'b0;
			chk(cpu_clk_en, 1'b1);
		end
		for (i = 0; i < 2; i++) begin
			sys_rst <= 1'b1;
			sleep_cmd <= 1'b0;
			primary_osc_config <= i[0] ? 3'h0 : 3'h5;
			repeat (3) @(posedge sys_clk);
			chk(device_reset, 1'b1);
			sys_rst <= 1'b0;
			for (n = 0; n < 400 && device_reset !== 1'b0; n++) @(posedge sys_clk);
			chk(n >= PW + 16 && n < 400, 1'b1);
			repeat (2) @(posedge sys_clk);
			chk(osc_pins_as_port, i[0]);
			chk(osc_out_pin_oe, !i[0]);
			chk(active_source, i[0] ? 2'h3 : 2'h2);
			m_off = 0;
			for (n = 0; n < 8; n++) begin
				@(posedge sys_clk);
				m_off += osc_out_pin;
			end
			chk(m_off, i[0] ? 0 : 4);
			sleep_cmd <= 1'b1;
			repeat (14) @(posedge sys_clk);
			chk(osc_out_pin, 1'b0);
			chk(fast_internal_osc_en, 1'b0);
		end
		give_verdict;
	end
endmodule // tb
